// file: hw/bspdc_top.v
`include "bspdc_defines.vh"

// ----------------------------------------
// Block overview
// ----------------------------------------
// Register map, one byte per aligned 32-bit word, upper bits read zero:
//   0x00 coarse set point code
//   0x04 fine set point code, reference enable in bit 7
//   0x08 undervoltage detect level
//   0x0c overvoltage detect level
//   0x10 driver control: mode, strength, bypasses, pulls, fast-off enables
//   0x14 analog enables: bit 7 overvoltage detect, bit 6 undervoltage detect
//   0x18 fault status: bit 0 undervoltage, bit 1 overvoltage, write one to clear
//   0x1c dead time codes: high side in bits 7-4, low side in bits 3-0
// Any other address, or a misaligned one, answers with an error response.
// Writes with byte lane zero disabled are dropped without an error.
//
// Bus timing:
//   Every transfer sees exactly one wait state.
//   The register takes its new value on the first access-phase edge.
//   Ready, error and read data are registered; ready and error stand for one cycle.
//   Read data holds its value until the next read.
//
// Pin inputs:
//   The sense code and the three switching events arrive from the analog side.
//   Each passes three flip-flops; a new value counts once stages two and
//   three agree, so a code caught mid-change is never acted upon.
//   This costs three to four cycles of latency on every event.
//
// Gate drive sequence:
//   A rising cycle start opens the cycle.
//   Unless bypassed, a high-side dead time gap runs first with both drives low.
//   The high drive then stands until the peak event.
//   Unless bypassed, a low-side dead time gap follows, both drives low again.
//   The low drive then stands until the next cycle start.
//   In diode emulation, the zero event ends the low drive early.
//   Both drives then rest low until the next cycle start.
//   Drives come from one state register, so they can never overlap.
//
// Dead time:
//   The gap is the programmed delay rounded up to whole clock periods.
//   At a 10 ns clock the gap is one to eight cycles long.
//   A finer delay would need a faster clock or an analog delay line.
//
// Faults:
//   Detection compares the settled sense code with each level code.
//   A disabled detector never raises its condition, whatever its level.
//   Each condition sets its sticky flag every cycle that it holds.
//   A clear in the same cycle as a detection loses to it.
//   With its fast-off bit set, a condition forces both drives low.
//   The sequencer parks idle and waits for a fresh cycle start to resume,
//   so a fault that clears mid-cycle never restarts a half cycle.
//
// Set point:
//   Coarse and fine codes go out only while the reference is enabled.
//   While disabled both codes read out as zero to the reference generator.
//   The register contents are kept, so enabling restores the old point.
//
// Reset:
//   Synchronous; all registers, flags, outputs and synchronisers clear.
//   Detection is therefore off until software enables it.

// Operation
// - Coarse code sets reference in 15 mV steps.
// - Fine code adds 0.82 mV per step above coarse setting.
// - Set point applies only when reference enable (fine bit 7) is one.
// - Coarse register is 8-bit read/write, reset to zero.
// - Fine code in bits 4-0; bits 6-5 read as zero.
// - Undervoltage flag sets below threshold, stays until software clears.
// - Overvoltage flag sets above threshold, stays until software clears.
// - Undervoltage threshold is 8-bit read/write, 15 mV per count.
// - Overvoltage threshold is 8-bit read/write, 15 mV per count.
// - Diode emulation ends low drive at zero crossing, both low till cycle start.
// - Synchronous mode keeps low drive high until next cycle start.
// - Control bit 7 selects diode emulation (1) or synchronous (0).
// - Control bit 6 selects high-side strength, one 1A, zero 2A.
// - Bypass bits 5 and 4 skip dead time; cleared inserts it.
// - Bit 3 enables negative sense pull-down, bit 2 positive sense pull-up.
// - Undervoltage fast-off bit forces both drives low on undervoltage.
// - Overvoltage fast-off bit forces both drives low on overvoltage.
// - Overvoltage detect disabled ignores overvoltage threshold.
// - Undervoltage detect disabled ignores undervoltage threshold.
module bspdc_top (
  input wire core_clk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [7:0] vout_sense_code,
  input wire cycle_start,
  input wire peak_reached,
  input wire low_side_zero,
  output reg high_side_gate_drive,
  output reg low_side_gate_drive,
  output reg high_side_strength_select,
  output reg neg_sense_pulldown_enable,
  output reg pos_sense_pullup_enable,
  output reg reference_enable,
  output reg [7:0] coarse_setpoint_code,
  output reg [4:0] fine_setpoint_code
);

  // Cycles of dead time for a 4-bit code: ceil((base + 4*code) / period)
  function [3:0] dly_cycles;
    input [3:0] code;
    input [6:0] base_ns;
    reg [7:0] ns;
    reg [31:0] full;
    begin
      ns = {1'b0, base_ns} + {2'b00, code, 2'b00};
      // Whole periods rounded up; the slice keeps the small count on purpose
      full = ns / `BSPDC_CLK_PERIOD_NS + ((ns % `BSPDC_CLK_PERIOD_NS) != 0 ? 1 : 0);
      dly_cycles = full[3:0];
    end
  endfunction

  // Pin inputs pass three flip-flops; accepted when stages two and three agree
  function [0:0] agreed;
    input s2;
    input s3;
    input prev;
    begin
      agreed = (s2 == s3) ? s3 : prev;
    end
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] output_voltage_coarse;
  reg [7:0] output_voltage_fine;
  reg [7:0] undervoltage_threshold;
  reg [7:0] overvoltage_threshold;
  reg [7:0] driver_peripheral_control;
  reg [7:0] analog_block_enables;
  reg [7:0] dead_time_codes;
  reg undervoltage_flag;
  reg overvoltage_flag;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  reg [7:0] sense_s1, sense_s2, sense_s3, sense_q;
  reg [2:0] cs_s1, cs_s2, cs_s3;
  reg cs_q, pk_q, lz_q, cs_prev;

  // First stage feeds only the second
  always @(posedge core_clk) begin
    if (srst) begin
      sense_s1 <= 8'h00;
      sense_s2 <= 8'h00;
      sense_s3 <= 8'h00;
      sense_q <= 8'h00;
      cs_s1 <= 3'h0;
      cs_s2 <= 3'h0;
      cs_s3 <= 3'h0;
      cs_q <= 1'b0;
      pk_q <= 1'b0;
      lz_q <= 1'b0;
      cs_prev <= 1'b0;
    end else begin
      sense_s1 <= vout_sense_code;
      sense_s2 <= sense_s1;
      sense_s3 <= sense_s2;
      if (sense_s2 == sense_s3)
        sense_q <= sense_s3;
      cs_s1 <= {cycle_start, peak_reached, low_side_zero};
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      cs_q <= agreed(cs_s2[2], cs_s3[2], cs_q);
      pk_q <= agreed(cs_s2[1], cs_s3[1], pk_q);
      lz_q <= agreed(cs_s2[0], cs_s3[0], lz_q);
      cs_prev <= cs_q;
    end
  end

  // Start of a switching cycle; idle level of the pin is low, so no false edge
  wire cycle_edge = cs_q & ~cs_prev;

  // ----------------------------------------
  // Fault detection
  // ----------------------------------------
  wire ov_det_en = analog_block_enables[`BSPDC_AB_OVDET_BIT];
  wire uv_det_en = analog_block_enables[`BSPDC_AB_UVDET_BIT];
  wire uv_cond = uv_det_en & (sense_q < undervoltage_threshold);
  wire ov_cond = ov_det_en & (sense_q > overvoltage_threshold);
  wire fast_off = (uv_cond & driver_peripheral_control[`BSPDC_PE_UVFAST_BIT]) |
    (ov_cond & driver_peripheral_control[`BSPDC_PE_OVFAST_BIT]);

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  wire wr_acc = psel & penable & pwrite & ~pready;
  wire rd_acc = psel & penable & ~pwrite & ~pready;
  wire addr_ok = (paddr <= `BSPDC_OFF_DEAD) && (paddr[1:0] == 2'b00);
  wire wr_lane = wr_acc & addr_ok & pstrb[0];
  wire clr_uv = wr_lane & (paddr == `BSPDC_OFF_STATUS) & pwdata[`BSPDC_ST_UV_BIT];
  wire clr_ov = wr_lane & (paddr == `BSPDC_OFF_STATUS) & pwdata[`BSPDC_ST_OV_BIT];
  reg [7:0] rd_byte;

  // Read multiplexer
  // Unmapped offsets read zero; the error flag is raised separately
  always @* begin
    case (paddr)
      `BSPDC_OFF_COARSE: rd_byte = output_voltage_coarse;
      `BSPDC_OFF_FINE: rd_byte = output_voltage_fine & `BSPDC_FINE_CODE_MASK;
      `BSPDC_OFF_UV_THR: rd_byte = undervoltage_threshold;
      `BSPDC_OFF_OV_THR: rd_byte = overvoltage_threshold;
      `BSPDC_OFF_PERIPH: rd_byte = driver_peripheral_control;
      `BSPDC_OFF_ANALOG: rd_byte = analog_block_enables;
      `BSPDC_OFF_STATUS: rd_byte = {6'h00, overvoltage_flag, undervoltage_flag};
      `BSPDC_OFF_DEAD: rd_byte = dead_time_codes;
      default: rd_byte = 8'h00;
    endcase
  end

  // Bus handshake and register writes; one wait state per access
  always @(posedge core_clk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      output_voltage_coarse <= `BSPDC_RST_COARSE;
      output_voltage_fine <= `BSPDC_RST_FINE;
      undervoltage_threshold <= `BSPDC_RST_THR;
      overvoltage_threshold <= `BSPDC_RST_THR;
      driver_peripheral_control <= `BSPDC_RST_PERIPH;
      analog_block_enables <= `BSPDC_RST_ANALOG;
      dead_time_codes <= `BSPDC_RST_DEAD;
    end else begin
      pready <= wr_acc | rd_acc;
      pslverr <= (wr_acc | rd_acc) & ~addr_ok;
      if (rd_acc)
        prdata <= addr_ok ? {24'h000000, rd_byte} : 32'h0000_0000;
      if (wr_lane) begin
        case (paddr)
          `BSPDC_OFF_COARSE: output_voltage_coarse <= pwdata[7:0];
          `BSPDC_OFF_FINE: output_voltage_fine <= pwdata[7:0] & `BSPDC_FINE_CODE_MASK;
          `BSPDC_OFF_UV_THR: undervoltage_threshold <= pwdata[7:0];
          `BSPDC_OFF_OV_THR: overvoltage_threshold <= pwdata[7:0];
          `BSPDC_OFF_PERIPH: driver_peripheral_control <= pwdata[7:0];
          `BSPDC_OFF_ANALOG: analog_block_enables <= pwdata[7:0];
          `BSPDC_OFF_DEAD: dead_time_codes <= pwdata[7:0];
          default: ;
        endcase
      end
    end
  end

  // Sticky fault flags; a new detection wins over a clear
  // A clear while the condition still holds leaves the flag set
  always @(posedge core_clk) begin
    if (srst) begin
      undervoltage_flag <= 1'b0;
      overvoltage_flag <= 1'b0;
    end else begin
      undervoltage_flag <= uv_cond | (undervoltage_flag & ~clr_uv);
      overvoltage_flag <= ov_cond | (overvoltage_flag & ~clr_ov);
    end
  end

  // ----------------------------------------
  // Set point and sense outputs
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (srst) begin
      reference_enable <= 1'b0;
      coarse_setpoint_code <= 8'h00;
      fine_setpoint_code <= 5'h00;
      high_side_strength_select <= 1'b0;
      neg_sense_pulldown_enable <= 1'b0;
      pos_sense_pullup_enable <= 1'b0;
    end else begin
      reference_enable <= output_voltage_fine[`BSPDC_FINE_REF_EN_BIT];
      // 15 mV per coarse step, 0.82 mV per fine step, zero when disabled
      coarse_setpoint_code <= output_voltage_fine[`BSPDC_FINE_REF_EN_BIT] ?
        output_voltage_coarse : 8'h00;
      fine_setpoint_code <= output_voltage_fine[`BSPDC_FINE_REF_EN_BIT] ?
        output_voltage_fine[4:0] : 5'h00;
      high_side_strength_select <= driver_peripheral_control[`BSPDC_PE_STRENGTH_BIT];
      neg_sense_pulldown_enable <= driver_peripheral_control[`BSPDC_PE_PULLDN_BIT];
      pos_sense_pullup_enable <= driver_peripheral_control[`BSPDC_PE_PULLUP_BIT];
    end
  end

  // ----------------------------------------
  // Gate drive sequencer
  // ----------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_HDLY = 3'h1;
  localparam [2:0] ST_HIGH = 3'h2;
  localparam [2:0] ST_LDLY = 3'h3;
  localparam [2:0] ST_LOW = 3'h4;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [3:0] dly_cnt;
  reg [3:0] next_dly_cnt;
  wire diode_mode = driver_peripheral_control[`BSPDC_PE_DIODE_BIT];
  wire h_bypass = driver_peripheral_control[`BSPDC_PE_HBYP_BIT];
  wire l_bypass = driver_peripheral_control[`BSPDC_PE_LBYP_BIT];
  wire [3:0] h_cycles = dly_cycles(dead_time_codes[7:4], 7'd11);
  wire [3:0] l_cycles = dly_cycles(dead_time_codes[3:0], 7'd4);

  // Next-state logic; dead time is a gap with both drives low
  always @* begin
    next_state = state;
    next_dly_cnt = dly_cnt;
    case (state)
      ST_IDLE, ST_LOW: begin
        if (state == ST_LOW && diode_mode && lz_q)
          next_state = ST_IDLE;
        if (cycle_edge) begin
          if (h_bypass) begin
            next_state = ST_HIGH;
          end else begin
            next_state = ST_HDLY;
            next_dly_cnt = h_cycles;
          end
        end
      end
      ST_HDLY: begin
        if (dly_cnt <= 4'h1)
          next_state = ST_HIGH;
        else
          next_dly_cnt = dly_cnt - 4'h1;
      end
      ST_HIGH: begin
        if (pk_q) begin
          if (l_bypass) begin
            next_state = ST_LOW;
          end else begin
            next_state = ST_LDLY;
            next_dly_cnt = l_cycles;
          end
        end
      end
      ST_LDLY: begin
        if (dly_cnt <= 4'h1)
          next_state = ST_LOW;
        else
          next_dly_cnt = dly_cnt - 4'h1;
      end
      default: next_state = ST_IDLE;
    endcase
    if (fast_off)
      next_state = ST_IDLE;
  end

  // State register and registered drives
  always @(posedge core_clk) begin
    if (srst) begin
      state <= ST_IDLE;
      dly_cnt <= 4'h0;
      high_side_gate_drive <= 1'b0;
      low_side_gate_drive <= 1'b0;
    end else begin
      state <= next_state;
      dly_cnt <= next_dly_cnt;
      high_side_gate_drive <= (next_state == ST_HIGH);
      low_side_gate_drive <= (next_state == ST_LOW);
    end
  end

endmodule // bspdc_top

// file: inc/bspdc_defines.vh
`ifndef BSPDC_DEFINES_VH
`define BSPDC_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define BSPDC_OFF_COARSE 12'h000
`define BSPDC_OFF_FINE 12'h004
`define BSPDC_OFF_UV_THR 12'h008
`define BSPDC_OFF_OV_THR 12'h00c
`define BSPDC_OFF_PERIPH 12'h010
`define BSPDC_OFF_ANALOG 12'h014
`define BSPDC_OFF_STATUS 12'h018
`define BSPDC_OFF_DEAD 12'h01c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BSPDC_FINE_REF_EN_BIT 7
`define BSPDC_FINE_CODE_MASK 8'h9f
`define BSPDC_PE_DIODE_BIT 7
`define BSPDC_PE_STRENGTH_BIT 6
`define BSPDC_PE_HBYP_BIT 5
`define BSPDC_PE_LBYP_BIT 4
`define BSPDC_PE_PULLDN_BIT 3
`define BSPDC_PE_PULLUP_BIT 2
`define BSPDC_PE_UVFAST_BIT 1
`define BSPDC_PE_OVFAST_BIT 0
`define BSPDC_AB_OVDET_BIT 7
`define BSPDC_AB_UVDET_BIT 6
`define BSPDC_ST_UV_BIT 0
`define BSPDC_ST_OV_BIT 1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define BSPDC_RST_COARSE 8'h00
`define BSPDC_RST_FINE 8'h00
`define BSPDC_RST_THR 8'h00
`define BSPDC_RST_PERIPH 8'h00
`define BSPDC_RST_ANALOG 8'h00
`define BSPDC_RST_DEAD 8'h00

// ----------------------------------------
// Step sizes and timing
// ----------------------------------------
`define BSPDC_COARSE_STEP_UV 15000
`define BSPDC_FINE_STEP_UV 820
`define BSPDC_CLK_PERIOD_NS 10
`define BSPDC_HDLY_BASE_NS 11
`define BSPDC_LDLY_BASE_NS 4
`define BSPDC_DLY_STEP_NS 4

`endif

// file: verif/bspdc_stage.sv
// ----
// Gate drive stage and switch node model
// ----
module bspdc_stage (
  input wire core_clk,
  input wire slow,
  input wire high_side_gate_drive,
  input wire low_side_gate_drive,
  output logic cycle_start = 1'b0,
  output logic peak_reached = 1'b0,
  output logic low_side_zero = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  int tick = 0;
  int hon = 0;
  int lon = 0;

  // Cycle timer, peak current and inductor zero crossing from on-times
  always @(posedge core_clk) begin
    tick <= (tick == 59) ? 0 : tick + 1;
    hon <= high_side_gate_drive ? hon + 1 : 0;
    lon <= low_side_gate_drive ? lon + 1 : 0;
    cycle_start <= tick < 6;
    peak_reached <= hon > (slow ? 12 : 3);
    low_side_zero <= lon > (slow ? 20 : 8);
  end
endmodule // bspdc_stage

// file: verif/bspdc_chk.sv
// ----
// Port checker
// ----
module bspdc_chk (
  input wire core_clk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire pready,
  input wire pslverr,
  input wire high_side_gate_drive,
  input wire low_side_gate_drive,
  input wire high_side_strength_select,
  input wire neg_sense_pulldown_enable,
  input wire pos_sense_pullup_enable,
  input wire reference_enable,
  input wire [7:0] coarse_setpoint_code,
  input wire [4:0] fine_setpoint_code
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // Completed write with its byte lane enabled
  wire wr_ok = psel & penable & pready & pwrite & pstrb[0];

  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_wr(logic [11:0] a);
    wr_ok && paddr == a;
  endsequence

  a_drive_excl: assert property (!(high_side_gate_drive && low_side_gate_drive))
    else $error("both gate drives high");
  a_ready_wait: assert property (s_wait |=> pready)
    else $error("no answer after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_phase: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  a_slverr_map: assert property (pready |-> pslverr == (paddr > 12'h01c || paddr[1:0] != 2'b00))
    else $error("wrong error response");
  a_ref_gate: assert property (!reference_enable |->
    coarse_setpoint_code == 8'h00 && fine_setpoint_code == 5'h00)
    else $error("codes live without enable");
  a_fine_write: assert property (s_wr(12'h004) |=> ##1
    reference_enable == $past(pwdata[7], 2) &&
    (!reference_enable || fine_setpoint_code == $past(pwdata[4:0], 2)))
    else $error("fine write not applied");
  a_strength_copy: assert property (s_wr(12'h010) |=> ##1
    high_side_strength_select == $past(pwdata[6], 2))
    else $error("strength bit not applied");
  a_pull_copy: assert property (s_wr(12'h010) |=> ##1
    {neg_sense_pulldown_enable, pos_sense_pullup_enable} == $past(pwdata[3:2], 2))
    else $error("pull bits not applied");
  a_reset_quiet: assert property ($fell(srst) |->
    !high_side_gate_drive && !low_side_gate_drive && !pready && !reference_enable)
    else $error("outputs active after reset");
endmodule // bspdc_chk

bind bspdc_top bspdc_chk chk (.*);

// file: verif/test_buck_setpoint_and_driver_control.sv
// ----
// Self-checking bench
// ----
module test_buck_setpoint_and_driver_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [7:0] vout_sense_code = 8'h80;
  logic slow = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, cycle_start, peak_reached, low_side_zero;
  wire high_side_gate_drive, low_side_gate_drive, high_side_strength_select;
  wire neg_sense_pulldown_enable, pos_sense_pullup_enable, reference_enable;
  wire [7:0] coarse_setpoint_code;
  wire [4:0] fine_setpoint_code;
  int fail_count = 0;
  int total_checks = 0;
  int seed = 32'h21e2;
  int hc, lc;
  logic [32:0] expq[$];
  logic [32:0] g;
  logic [31:0] v;
  logic [7:0] cfg;

  bspdc_top dut (.*);
  bspdc_stage stage (.*);

  initial forever #5 core_clk = ~core_clk;

  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One APB transfer, upper data bits random
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    r = $random(seed);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {r[31:8], d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(1'b0, a, 8'h00);
  endtask

  // Counts drive-high cycles over a window
  task automatic drv(input int n);
    hc = 0;
    lc = 0;
    repeat (n) begin
      @(posedge core_clk);
      hc += high_side_gate_drive;
      lc += low_side_gate_drive;
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Read answers compared with the oldest expectation
  always @(posedge core_clk) begin
    if (pready === 1'b1 && pwrite === 1'b0 && expq.size() > 0) begin
      check({pslverr, prdata}, expq.pop_front());
    end
  end

  // Hang guard
  initial begin
    #100000;
    fail_count++;
    $display("BAD %0t timeout", $time);
    print_verdict();
  end

  initial begin
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    rd(12'h000, 33'h0);
    rd(12'h004, 33'h0);
    rd(12'h010, 33'h0);
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      apb(1'b1, 12'(4 * (i % 4)), v[7:0]);
      rd(12'(4 * (i % 4)), {25'h0, v[7:0] & ((i % 4 == 1) ? 8'h9f : 8'hff)});
    end
    apb(1'b1, 12'h000, 8'h5a);
    apb(1'b1, 12'h004, 8'h15);
    check({25'h0, coarse_setpoint_code}, 33'h0);
    apb(1'b1, 12'h004, 8'hf3);
    g = {20'h0, coarse_setpoint_code, fine_setpoint_code};
    check(g, {20'h0, 8'h5a, 5'h13});
    pstrb <= 4'he;
    apb(1'b1, 12'h000, 8'hff);
    pstrb <= 4'hf;
    rd(12'h000, 33'h5a);
    rd(12'h020, {1'b1, 32'h0});
    rd(12'h002, {1'b1, 32'h0});
    $display("test registers done");
    for (int m = 0; m < 2; m++) begin
      v = $random(seed);
      cfg = {m[0], v[6:2], 2'b00};
      apb(1'b1, 12'h010, cfg);
      drv(120);
      check({32'h0, lc > 60}, {32'h0, m == 0});
      check({32'h0, hc > 0}, 33'h1);
      g = {30'h0, high_side_strength_select, neg_sense_pulldown_enable, pos_sense_pullup_enable};
      check(g, {30'h0, cfg[6], cfg[3:2]});
    end
    $display("test modes done");
    apb(1'b1, 12'h008, 8'h40);
    apb(1'b1, 12'h00c, 8'hc0);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, 12'h014, 8'hc0);
      apb(1'b1, 12'h010, 8'h03);
      apb(1'b1, 12'h018, 8'h03);
      vout_sense_code <= k ? 8'hd0 : 8'h20;
      repeat (8) @(posedge core_clk);
      drv(60);
      check({32'h0, hc + lc == 0}, 33'h1);
      vout_sense_code <= 8'h80;
      repeat (8) @(posedge core_clk);
      rd(12'h018, k ? 33'h2 : 33'h1);
      apb(1'b1, 12'h018, 8'h03);
      rd(12'h018, 33'h0);
      slow <= 1'b1;
      drv(120);
      check({32'h0, hc > 0}, 33'h1);
      slow <= 1'b0;
      apb(1'b1, 12'h014, 8'h00);
      vout_sense_code <= k ? 8'hd0 : 8'h20;
      repeat (8) @(posedge core_clk);
      rd(12'h018, 33'h0);
      vout_sense_code <= 8'h80;
    end
    $display("test faults done");
    print_verdict();
  end
endmodule // test_buck_setpoint_and_driver_control
